// ===== hw/serializer_pkg.sv
package serializer_pkg;

	// ----------------------------------------
	// word and frame layout
	// ----------------------------------------
	localparam int         DATA_W     = 10;
	localparam int         FRAME_W    = 12;
	localparam logic       START_BIT  = 1'b1;
	localparam logic       STOP_BIT   = 1'b0;
	localparam logic [11:0] SYNC_FRAME = 12'h03F; // lsb leaves first: six ones, six zeros
	localparam logic [3:0] FRAME_LAST = 4'(FRAME_W - 1);
	localparam logic [2:0] SYNC_GATE  = 3'h5;     // word clocks of sync before capture stops

	// ----------------------------------------
	// word clock window, core clock at 4 ns
	// ----------------------------------------
	localparam int         CLK_PERIOD_PS      = 4000;
	localparam int         WORD_PERIOD_MIN_PS = 25000;
	localparam int         WORD_PERIOD_MAX_PS = 62500;
	localparam int         WORD_CYC_MIN       = (WORD_PERIOD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int         WORD_CYC_MAX       = WORD_PERIOD_MAX_PS / CLK_PERIOD_PS;
	localparam logic [7:0] PER_LO             = 8'(WORD_CYC_MIN - 1);
	localparam logic [7:0] PER_HI             = 8'(WORD_CYC_MAX - 1);
	localparam logic [7:0] PER_SAT            = 8'hFF;

	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [3:0] REG_STATUS    = 4'h0;
	localparam logic [3:0] REG_LOCK_WAIT = 4'h4;
	localparam logic [3:0] REG_FRAMES    = 4'h8;
	localparam logic [3:0] REG_DROPS     = 4'hC;
	localparam logic [7:0] LOCK_WAIT_RST = 8'h04;
	localparam int         STAT_LOCKED   = 0;
	localparam int         STAT_SYNC     = 1;
	localparam int         STAT_IGNORE   = 2;
	localparam int         STAT_DRIVE    = 3;
	localparam int         STAT_EMPTY    = 4;
	localparam int         STAT_STATE    = 8;
	localparam int         FIFO_DEPTH_DEF = 4;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_LOCK = 3'b010,
		ST_RUN  = 3'b100
	} link_state_t;

endpackage : serializer_pkg

// ===== hw/word_fifo_if.sv
`timescale 1ns/1ps
// ----------------------------------------
// word path between capture and serializer
// ----------------------------------------
interface word_fifo_if #(
	parameter int W = 10
);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;
	logic         flush;

	modport store (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data);
	modport user  (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data);
endinterface : word_fifo_if

// ===== hw/word_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------
// small word buffer, flushable
// ----------------------------------------
module word_fifo
#(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
)
(
	// clock and reset
	input  wire logic  core_clk,
	input  wire logic  resetn,
	// both buffer sides
	word_fifo_if.store f
);
	localparam int            PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int            CW   = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wp_r;
	logic [PW-1:0]    wp_nxt;
	logic [PW-1:0]    rp_r;
	logic [PW-1:0]    rp_nxt;
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             push;
	logic             pop;

	// flags come from the count, so full and empty never lie
	assign f.wr_ready = (cnt_r != FULL);
	assign f.rd_valid = (cnt_r != '0);
	assign f.rd_data  = mem_r[rp_r];
	assign push       = f.wr_valid && f.wr_ready && !f.flush;
	assign pop        = f.rd_valid && f.rd_ready && !f.flush;

	// pointer and count update, flush wins
	always_comb
	begin
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		cnt_nxt = cnt_r;
		if (push)
			wp_nxt = (wp_r == LAST) ? '0 : wp_r + 1'b1;
		if (pop)
			rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
		if (f.flush)
		begin
			wp_nxt  = '0;
			rp_nxt  = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage needs no reset; the count guards stale words
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_r[wp_r] <= f.wr_data;
	end
endmodule : word_fifo

// ===== hw/word_serializer.sv
`timescale 1ns/1ps
// Behaviour
// - outputs high-z until power-on reset releases
// - send nothing before word clock lock
// - sync frame is six ones, six zeros
// - sync ends only when both requests low
// - capture edge chosen by edge select
// - five sync word clocks block data capture
// - frame adds start one, stop zero
// - twelve serial bits per frame
// - data driven only enabled, awake, unsynced
// - either request alone starts sync
// - sleep stops lock, outputs high-z
// - relock after sleep before data
// - output enable low gives high-z
// - enable return resumes previous state
module word_serializer
	import serializer_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
	// clock and power-on reset
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// parallel word side
	input  wire logic              word_clock,
	input  wire logic [DATA_W-1:0] parallel_word_in,
	input  wire logic              capture_edge_select,
	// control pins
	input  wire logic              sync_request_a,
	input  wire logic              sync_request_b,
	input  wire logic              output_enable,
	input  wire logic              sleep_n,
	// differential serial output pair
	output logic                   serial_pos_out,
	output logic                   serial_pos_oe_n,
	output logic                   serial_neg_out,
	output logic                   serial_neg_oe_n,
	// avalon-mm slave
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	link_state_t       st_r;
	link_state_t       st_nxt;
	logic [7:0]        per_r;
	logic [7:0]        per_nxt;
	logic [7:0]        good_r;
	logic [7:0]        good_nxt;
	logic [7:0]        lock_wait_r;
	logic [7:0]        lock_wait_nxt;
	logic              wc_prev_r;
	logic              wc_rise;
	logic              wc_fall;
	logic              per_good;
	logic              run;
	logic              sync_any;
	logic [2:0]        sync_cnt_r;
	logic [2:0]        sync_cnt_nxt;
	logic              ignore_data;
	logic              cap_edge;
	logic              push;
	logic [15:0]       drops_r;
	logic [15:0]       drops_nxt;
	logic [FRAME_W-1:0] sh_r;
	logic [FRAME_W-1:0] sh_nxt;
	logic [3:0]        cnt_r;
	logic [3:0]        cnt_nxt;
	logic              busy_r;
	logic              busy_nxt;
	logic              load;
	logic              sync_sel;
	logic [15:0]       frames_r;
	logic [15:0]       frames_nxt;
	logic              pos_r;
	logic              neg_r;
	logic              oe_n_r;
	logic              oe_n_nxt;
	logic              wait_r;
	logic              wait_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic [31:0]       status;

	word_fifo_if #(.W(DATA_W)) fq ();

	word_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk (core_clk),
		.resetn   (resetn),
		.f        (fq)
	);

	// ----------------------------------------
	// word clock edges and lock tracking
	// ----------------------------------------
	assign wc_rise  = word_clock && !wc_prev_r;
	assign wc_fall  = !word_clock && wc_prev_r;
	assign per_good = (per_r >= PER_LO) && (per_r <= PER_HI);
	assign sync_any = sync_request_a || sync_request_b;
	assign run      = (st_nxt == ST_RUN);

	// lock means a run of in-window word clock periods; sleep kills it
	always_comb
	begin
		st_nxt   = st_r;
		per_nxt  = (per_r == PER_SAT) ? per_r : per_r + 8'h01;
		good_nxt = good_r;
		if (wc_rise)
		begin
			per_nxt  = 8'h00;
			good_nxt = !per_good ? 8'h00 : (good_r == PER_SAT) ? good_r : good_r + 8'h01;
		end
		unique case (st_r)
			ST_OFF:
			begin
				st_nxt   = ST_LOCK;
				good_nxt = 8'h00;
			end
			ST_LOCK:
				if (good_r >= lock_wait_r)
					st_nxt = ST_RUN;
			ST_RUN:
				if ((per_r > PER_HI) || (wc_rise && !per_good))
					st_nxt = ST_LOCK;
			default:
				st_nxt = ST_OFF;
		endcase
		if (!sleep_n)
		begin
			st_nxt   = ST_OFF;
			good_nxt = 8'h00;
		end
	end

	// power-on reset holds everything off until release
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r      <= ST_OFF;
			per_r     <= PER_SAT;
			good_r    <= 8'h00;
			wc_prev_r <= 1'b0;
		end
		else
		begin
			st_r      <= st_nxt;
			per_r     <= per_nxt;
			good_r    <= good_nxt;
			wc_prev_r <= word_clock;
		end
	end

	// ----------------------------------------
	// capture into the word buffer
	// ----------------------------------------
	assign ignore_data = (sync_cnt_r == SYNC_GATE);
	assign cap_edge    = capture_edge_select ? wc_rise : wc_fall;
	assign push        = run && cap_edge && !ignore_data;
	assign fq.wr_valid = push;
	assign fq.wr_data  = parallel_word_in;
	assign fq.flush    = !run; // stale words must not outlive a lock loss

	// the source cannot be stalled, so a full buffer drops and counts
	always_comb
	begin
		sync_cnt_nxt = sync_cnt_r;
		drops_nxt    = drops_r;
		if (!sync_any)
			sync_cnt_nxt = 3'h0;
		else if (wc_rise && !ignore_data)
			sync_cnt_nxt = sync_cnt_r + 3'h1;
		if (push && !fq.wr_ready && (drops_r != 16'hFFFF))
			drops_nxt = drops_r + 16'h0001;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync_cnt_r <= 3'h0;
			drops_r    <= 16'h0000;
		end
		else
		begin
			sync_cnt_r <= sync_cnt_nxt;
			drops_r    <= drops_nxt;
		end
	end

	// ----------------------------------------
	// frame serializer
	// ----------------------------------------
	// one bit per core clock; next frame loads on the stop bit cycle
	always_comb
	begin
		sh_nxt      = sh_r;
		cnt_nxt     = cnt_r;
		busy_nxt    = busy_r;
		frames_nxt  = frames_r;
		load        = 1'b0;
		sync_sel    = 1'b0;
		fq.rd_ready = 1'b0;
		if (busy_r && (cnt_r != 4'h0))
		begin
			sh_nxt  = sh_r >> 1;
			cnt_nxt = cnt_r - 4'h1;
		end
		else if (run)
		begin
			busy_nxt = 1'b0;
			sh_nxt   = '0;
			if (sync_any)
			begin
				load     = 1'b1;
				sync_sel = 1'b1;
				sh_nxt   = SYNC_FRAME;
			end
			else if (output_enable && fq.rd_valid)
			begin
				load        = 1'b1;
				fq.rd_ready = 1'b1;
				sh_nxt      = {STOP_BIT, fq.rd_data, START_BIT};
			end
			if (load)
			begin
				busy_nxt   = 1'b1;
				cnt_nxt    = FRAME_LAST;
				frames_nxt = frames_r + 16'h0001;
			end
		end
		if (!run)
		begin
			busy_nxt = 1'b0;
			sh_nxt   = '0;
			cnt_nxt  = 4'h0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sh_r     <= '0;
			cnt_r    <= 4'h0;
			busy_r   <= 1'b0;
			frames_r <= 16'h0000;
		end
		else
		begin
			sh_r     <= sh_nxt;
			cnt_r    <= cnt_nxt;
			busy_r   <= busy_nxt;
			frames_r <= frames_nxt;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// enable gates the pins and data frame loads, so lock state carries on while high-z
	assign oe_n_nxt = !(output_enable && sleep_n && run);
	assign serial_pos_out  = pos_r;
	assign serial_neg_out  = neg_r;
	assign serial_pos_oe_n = oe_n_r;
	assign serial_neg_oe_n = oe_n_r;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pos_r  <= 1'b0;
			neg_r  <= 1'b1;
			oe_n_r <= 1'b1;
		end
		else
		begin
			pos_r  <= sh_nxt[0];
			neg_r  <= !sh_nxt[0];
			oe_n_r <= oe_n_nxt;
		end
	end

	// ----------------------------------------
	// avalon register slave
	// ----------------------------------------
	always_comb
	begin
		status                             = 32'h0000_0000;
		status[STAT_LOCKED]                = (st_r == ST_RUN);
		status[STAT_SYNC]                  = sync_any;
		status[STAT_IGNORE]                = ignore_data;
		status[STAT_DRIVE]                 = !oe_n_r;
		status[STAT_EMPTY]                 = !fq.rd_valid;
		status[STAT_STATE +: 3]            = st_r;
	end

	// one wait cycle: read data is snapped while waitrequest is still high
	always_comb
	begin
		wait_nxt      = 1'b1;
		rdata_nxt     = rdata_r;
		lock_wait_nxt = lock_wait_r;
		if ((avs_read || avs_write) && wait_r)
		begin
			wait_nxt = 1'b0;
			unique case (avs_address)
				REG_STATUS:    rdata_nxt = status;
				REG_LOCK_WAIT: rdata_nxt = {24'h000000, lock_wait_r};
				REG_FRAMES:    rdata_nxt = {16'h0000, frames_r};
				REG_DROPS:     rdata_nxt = {16'h0000, drops_r};
				default:       rdata_nxt = 32'h0000_0000;
			endcase
		end
		if (avs_write && !wait_r && (avs_address == REG_LOCK_WAIT))
			lock_wait_nxt = avs_writedata[7:0];
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wait_r      <= 1'b1;
			rdata_r     <= 32'h0000_0000;
			lock_wait_r <= LOCK_WAIT_RST;
		end
		else
		begin
			wait_r      <= wait_nxt;
			rdata_r     <= rdata_nxt;
			lock_wait_r <= lock_wait_nxt;
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_six_ones;
		sh_r[0] [*6];
	endsequence

	sequence s_six_zeros;
		!sh_r[0] [*6];
	endsequence

	a_hiz_unlocked:
	assert property (st_r != ST_RUN |-> serial_pos_oe_n && serial_neg_oe_n && !busy_r)
		else $error("serial pair driven or busy while not locked");

	a_lock_before_run:
	assert property (st_r == ST_LOCK ##1 st_r == ST_RUN |-> $past(good_r) >= $past(lock_wait_r))
		else $error("entered run before enough good word clock periods");

	a_sync_shape:
	assert property (load && sync_sel |=> s_six_ones ##1 s_six_zeros)
		else $error("sync frame is not six ones then six zeros");

	a_data_gating:
	assert property (fq.rd_ready |-> output_enable && sleep_n && !sync_request_a && !sync_request_b)
		else $error("data frame taken while sync requested or output disabled");

	a_capture_edge:
	assert property (push |-> (capture_edge_select ? (word_clock && !wc_prev_r) : (!word_clock && wc_prev_r)))
		else $error("word captured on the wrong edge");

	a_data_ignored:
	assert property (sync_any && wc_rise [*1] ##0 (sync_cnt_r == 3'h4) |=> !push [*1])
		else $error("data captured after five sync word clocks");

	a_frame_bits:
	assert property (disable iff (!resetn || !run)
		load && !sync_sel |=> sh_r[0] ##1 (sh_r[0] == $past(fq.rd_data[0], 2)) ##10 !sh_r[0])
		else $error("data frame framing or bit order wrong");

	a_frame_length:
	assert property (load |=> !load [*8] ##1 !load [*3])
		else $error("frame shorter than twelve bits");

	a_oe_off:
	assert property (!output_enable |=> serial_pos_oe_n && serial_neg_oe_n)
		else $error("serial pair driven with output enable low");

	a_sleep_off:
	assert property (!sleep_n |=> st_r == ST_OFF && serial_neg_oe_n)
		else $error("sleep did not stop lock and release the pair");

endmodule : word_serializer

// ===== tb/word_source.sv
`timescale 1ns/1ps
// ------
// word source and serial receiver
// ------
module word_source
	import serializer_pkg::*;
(
	// clock and reset
	input  wire logic			core_clk,
	input  wire logic			resetn,
	// word side
	input  wire logic			run,
	output logic				word_clock,
	output logic [DATA_W-1:0]	word,
	// serial pair
	input  wire logic			pos,
	input  wire logic			neg,
	input  wire logic			oe_a,
	input  wire logic			oe_b,
	// decoded frames
	output logic [FRAME_W-1:0]	frame,
	output int					n_frames,
	output int					n_bad
);
	logic [3:0]	ph;
	logic [8:0]	cnt;
	int			bn;

	// 14 cycles a word, 17.9 MHz; clock stands still when not running
	// a rise sees the flag-1 word, a fall the flag-0 word, 3 cycles clear
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			ph <= 4'h0;
			cnt <= 9'h000;
			word_clock <= 1'b0;
			word <= 10'h000;
		end
		else if (run)
		begin
			ph <= (ph == 4'hD) ? 4'h0 : ph + 4'h1;
			word_clock <= (ph < 4'h7);
			if (ph == 4'h3)
				word <= {1'b0, cnt};
			if (ph == 4'hA)
			begin
				word <= {1'b1, cnt};
				cnt <= cnt + 9'h001;
			end
		end

	// a high bit on a driven idle line opens a frame; bit n sits at n
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
		begin
			bn <= 0;
			n_frames <= 0;
			n_bad <= 0;
			frame <= '0;
		end
		else
		begin
			if (oe_a !== 1'b0)
				bn <= 0;
			else if (bn == 0 && pos === 1'b1)
			begin
				frame[0] <= 1'b1;
				bn <= 1;
			end
			else if (bn > 0)
			begin
				frame[bn] <= pos;
				bn <= (bn == 11) ? 0 : bn + 1;
				n_frames <= n_frames + int'(bn == 11);
			end
			if (oe_a !== oe_b || (oe_a === 1'b0 && neg !== ~pos))
				n_bad <= n_bad + 1;
		end
endmodule : word_source

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// ------
// serializer bench
// ------
module tb_top
	import serializer_pkg::*;
;
	logic				core_clk;
	logic				resetn;
	logic				run;
	logic				word_clock;
	logic [DATA_W-1:0]	parallel_word_in;
	logic				capture_edge_select;
	logic				sync_request_a;
	logic				sync_request_b;
	logic				output_enable;
	logic				sleep_n;
	logic				pos;
	logic				pos_oe_n;
	logic				neg;
	logic				neg_oe_n;
	logic [3:0]			avs_address;
	logic				avs_read;
	logic				avs_write;
	logic [31:0]		avs_writedata;
	logic [31:0]		avs_readdata;
	logic				avs_waitrequest;
	logic [FRAME_W-1:0]	frame;
	logic [FRAME_W-1:0]	f;
	logic [FRAME_W-1:0]	p;
	logic [31:0]		q;
	logic [31:0]		d0;
	int					n_frames;
	int					n_bad;
	int					n_fail;
	int					compares;
	int					i;

	word_serializer uut (.core_clk(core_clk), .resetn(resetn), .word_clock(word_clock),
		.parallel_word_in(parallel_word_in), .capture_edge_select(capture_edge_select),
		.sync_request_a(sync_request_a), .sync_request_b(sync_request_b),
		.output_enable(output_enable), .sleep_n(sleep_n), .serial_pos_out(pos),
		.serial_pos_oe_n(pos_oe_n), .serial_neg_out(neg), .serial_neg_oe_n(neg_oe_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));

	word_source src (.core_clk(core_clk), .resetn(resetn), .run(run), .word_clock(word_clock),
		.word(parallel_word_in), .pos(pos), .neg(neg), .oe_a(pos_oe_n), .oe_b(neg_oe_n),
		.frame(frame), .n_frames(n_frames), .n_bad(n_bad));

	// 250 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task tally_and_finish;
		n_fail += n_bad;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// one bus cycle; held until waitrequest is seen low at an edge
	task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (i = 0; i < 50; i++)
		begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (i == 50)
		begin
			n_fail++;
			tally_and_finish();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : av

	// next decoded frame, bounded so a dead line cannot hang the run
	task nf;
		d0 = n_frames;
		for (i = 0; i < 400 && n_frames == d0; i++)
			@(posedge core_clk);
		if (n_frames == d0)
		begin
			n_fail++;
			tally_and_finish();
		end
		f = frame;
	endtask : nf

	task woe(input logic v);
		for (i = 0; i < 400 && pos_oe_n !== v; i++)
			@(posedge core_clk);
		chk(pos_oe_n, v);
		if (pos_oe_n !== v)
			tally_and_finish();
	endtask : woe

	task t_regs;
		av(1'b0, REG_LOCK_WAIT, 32'h0);
		chk(q, 32'(LOCK_WAIT_RST));
		av(1'b1, REG_LOCK_WAIT, 32'hFFFFFFFF);
		av(1'b0, REG_LOCK_WAIT, 32'h0);
		chk(q, 32'h000000FF);
		av(1'b1, REG_FRAMES, 32'h0000FFFF);
		av(1'b0, REG_FRAMES, 32'h0);
		chk(q, 32'h0);
		av(1'b0, 4'h6, 32'h0);
		chk(q, 32'h0);
		av(1'b1, REG_LOCK_WAIT, 32'(LOCK_WAIT_RST));
		$display("test regs done");
	endtask : t_regs

	// no word clock, no drive; lock needs several good periods
	task t_lock;
		repeat (60) @(posedge core_clk);
		chk(pos_oe_n, 1'b1);
		run <= 1'b1;
		repeat (30) @(posedge core_clk);
		chk(pos_oe_n, 1'b1);
		woe(1'b0);
		av(1'b0, REG_STATUS, 32'h0);
		chk(q[STAT_LOCKED], 1'b1);
		$display("test lock done");
	endtask : t_lock

	// the flag bit tells which edge took the word; counts must run on
	task t_data(input logic e);
		capture_edge_select <= e;
		for (int k = 0; k < 4; k++)
			nf();
		for (int k = 0; k < 6; k++)
		begin
			p = f;
			nf();
			chk(f[0], START_BIT);
			chk(f[11], STOP_BIT);
			chk(f[10], e);
			chk(f[9:1], 9'(p[9:1] + 9'h001));
		end
		$display("test data done");
	endtask : t_data

	// one line starts sync, the other holds it, both low ends it
	task t_sync(input logic fa);
		sync_request_a <= fa;
		sync_request_b <= !fa;
		for (int k = 0; k < 8; k++)
			nf();
		chk(f, SYNC_FRAME);
		av(1'b0, REG_STATUS, 32'h0);
		chk(q[STAT_IGNORE], 1'b1);
		sync_request_a <= 1'b1;
		sync_request_b <= 1'b1;
		nf();
		sync_request_a <= !fa;
		sync_request_b <= fa;
		for (int k = 0; k < 3; k++)
			nf();
		chk(f, SYNC_FRAME);
		sync_request_a <= 1'b0;
		sync_request_b <= 1'b0;
		for (int k = 0; k < 4 && f === SYNC_FRAME; k++)
			nf();
		chk(f[11:10], {STOP_BIT, capture_edge_select});
		$display("test sync done");
	endtask : t_sync

	// released pair stalls the buffer until it refuses words
	task t_oe;
		av(1'b0, REG_DROPS, 32'h0);
		d0 = q;
		output_enable <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk({pos_oe_n, neg_oe_n}, 2'b11);
		repeat (140) @(posedge core_clk);
		chk(pos_oe_n, 1'b1);
		av(1'b0, REG_DROPS, 32'h0);
		chk(q - d0 > 32'h3, 1'b1);
		output_enable <= 1'b1;
		woe(1'b0);
		for (int k = 0; k < 6; k++)
			nf();
		chk(f[11:10], {STOP_BIT, capture_edge_select});
		$display("test enable done");
	endtask : t_oe

	task t_sleep;
		sleep_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		chk({pos_oe_n, neg_oe_n}, 2'b11);
		av(1'b0, REG_STATUS, 32'h0);
		chk(q[STAT_LOCKED], 1'b0);
		sleep_n <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk(pos_oe_n, 1'b1);
		woe(1'b0);
		nf();
		chk(f[0], START_BIT);
		// system resyncs the far receiver after wake by pulsing a request
		sync_request_a <= 1'b1;
		nf();
		nf();
		chk(f, SYNC_FRAME);
		sync_request_a <= 1'b0;
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({pos_oe_n, neg_oe_n, pos}, 3'b110);
		resetn <= 1'b1;
		$display("test sleep done");
	endtask : t_sleep

	initial
	begin
		resetn = 1'b0;
		run = 1'b0;
		capture_edge_select = 1'b1;
		sync_request_a = 1'b0;
		sync_request_b = 1'b0;
		output_enable = 1'b1;
		sleep_n = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		n_fail = 0;
		compares = 0;
		repeat (8) @(posedge core_clk);
		chk({pos_oe_n, neg_oe_n, pos}, 3'b110);
		resetn <= 1'b1;
		t_regs();
		t_lock();
		t_data(1'b1);
		t_data(1'b0);
		t_sync(1'b1);
		t_sync(1'b0);
		t_oe();
		t_sleep();
		tally_and_finish();
	end
endmodule : tb_top
